// ===== include/oit_pkg.sv
// package for the internal oscillator auto trim block
// assumes a 10 MHz hclk and an AHB-Lite register bus with 32-bit data
package oit_pkg;
    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 10000000;
    localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_OSC_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_OSC_STATUS   = 8'h04;
    localparam logic [7:0] OFF_OSC_TRIM     = 8'h08;
    localparam logic [7:0] OFF_TRIM_CONTROL = 8'h0c;
    localparam logic [7:0] OFF_TRIM_IRQ     = 8'h10;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int unsigned CTL_PLL_EN    = 7;
    localparam int unsigned CTL_PLL_MULT  = 6;
    localparam int unsigned CTL_FREQ_LSB  = 2;
    localparam int unsigned TC_ENABLE     = 7;
    localparam int unsigned TC_HOLD       = 6;
    localparam int unsigned TC_REF_SEL    = 4;
    localparam int unsigned TC_LOCKED     = 3;
    localparam int unsigned TC_RANGE      = 1;
    localparam int unsigned IRQ_FLAG      = 0;
    localparam int unsigned IRQ_ENABLE    = 1;

    // -------------------------------------------------------------
    // reset values and trim code limits
    // -------------------------------------------------------------
    localparam logic [3:0] FREQ_SEL_RESET = 4'h7;
    localparam logic [1:0] CLK_SEL_RESET  = 2'h0;
    localparam logic [6:0] TRIM_RESET     = 7'h00;
    localparam logic [6:0] TRIM_MAX       = 7'h3f;
    localparam logic [6:0] TRIM_MIN       = 7'h40;

    // -------------------------------------------------------------
    // measurement: oscillator ticks expected per reference period, tolerances, pll multiplier codes
    // -------------------------------------------------------------
    localparam int unsigned    CNT_W        = 16;
    localparam logic [15:0]    EXPECT_USB   = 16'h3e80;
    localparam logic [15:0]    EXPECT_XTAL  = 16'h01e8;
    localparam logic [15:0]    TOL_USB      = 16'h0020;
    localparam logic [15:0]    TOL_XTAL     = 16'h0001;

    localparam logic [2:0]     PLL_MULT_3X  = 3'h3;
    localparam logic [2:0]     PLL_MULT_4X  = 3'h4;
endpackage

// ===== src/oit_auto_trim.sv
// internal oscillator auto trim: registers, AHB-Lite slave, trim engine
// assumes ref and oscillator tick inputs synchronous to hclk, one slave on the bus
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module oit_auto_trim (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sleep_mode,
    input  wire logic        osc_tick,
    input  wire logic        usb_frame_ref_clock,
    input  wire logic        watch_crystal_ref_clock,
    input  wire logic        timer1_crystal_enable,
    input  wire logic        secondary_osc_ready,
    input  wire logic        pll_ready_flag,
    input  wire logic        startup_timer_status,
    input  wire logic        fast_rc_ready,
    input  wire logic        slow_rc_ready,
    input  wire logic        fast_rc_stable,
    output logic [6:0]       osc_trim_value,
    output logic             pll_soft_enable,
    output logic [2:0]       pll_multiplier,
    output logic [3:0]       internal_freq_select,
    output logic [3:0]       freq_div_log2,
    output logic             use_slow_rc,
    output logic [1:0]       system_clock_select,
    output logic             trim_irq
);
    // -------------------------------------------------------------
    // engine state
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        OIT_IDLE    = 2'b00,
        OIT_PRIME   = 2'b01,
        OIT_MEASURE = 2'b10
    } oit_state_t;

    oit_state_t  state;
    oit_state_t  next_state;

    logic        pll_mult_sel;
    logic        trim_enable;
    logic        trim_update_hold;
    logic        trim_ref_select;
    logic        trim_locked;
    logic        trim_out_of_range;
    logic        trim_irq_flag;
    logic        trim_irq_enable;
    logic [15:0] tick_count;

    // data phase capture
    logic        wr_pend;
    logic [7:0]  wr_addr;

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    wire         bus_take;
    wire         rd_take;
    wire         wr_take;
    wire         wr_ctl;
    wire         wr_trim;
    wire         wr_tc;
    wire         wr_irq;
    wire  [7:0]  ctl_byte;
    wire  [7:0]  stat_byte;
    wire  [7:0]  trim_byte;
    wire  [7:0]  tc_byte;
    wire  [7:0]  irq_byte;
    wire  [7:0]  rd_byte;

    assign bus_take = hsel & hready & htrans[1];
    assign rd_take  = bus_take & ~hwrite;
    assign wr_take  = bus_take & hwrite;
    assign wr_ctl   = wr_pend & (wr_addr == oit_pkg::OFF_OSC_CONTROL);
    assign wr_trim  = wr_pend & (wr_addr == oit_pkg::OFF_OSC_TRIM);
    assign wr_tc    = wr_pend & (wr_addr == oit_pkg::OFF_TRIM_CONTROL);
    assign wr_irq   = wr_pend & (wr_addr == oit_pkg::OFF_TRIM_IRQ);

    assign ctl_byte  = {pll_soft_enable, pll_mult_sel, internal_freq_select,
                        system_clock_select};
    assign stat_byte = {secondary_osc_ready, pll_ready_flag, startup_timer_status,
                        fast_rc_ready, 2'b00, slow_rc_ready, fast_rc_stable};
    assign trim_byte = {1'b0, osc_trim_value};
    assign tc_byte   = {trim_enable, trim_update_hold, 1'b0, trim_ref_select,
                        trim_locked, 1'b0, trim_out_of_range, 1'b0};
    assign irq_byte  = {6'h00, trim_irq_enable, trim_irq_flag};

    // unmapped offsets read zero and still answer okay
    assign rd_byte = (haddr[7:0] == oit_pkg::OFF_OSC_CONTROL)  ? ctl_byte  :
                     (haddr[7:0] == oit_pkg::OFF_OSC_STATUS)   ? stat_byte :
                     (haddr[7:0] == oit_pkg::OFF_OSC_TRIM)     ? trim_byte :
                     (haddr[7:0] == oit_pkg::OFF_TRIM_CONTROL) ? tc_byte   :
                     (haddr[7:0] == oit_pkg::OFF_TRIM_IRQ)     ? irq_byte  : 8'h00;

    // -------------------------------------------------------------
    // frequency map
    // -------------------------------------------------------------
    // 1xxx halves from 16 MHz; 01xx continues from 500 kHz; 000x is the slow rc
    wire [3:0] next_div;
    wire       next_slow;
    wire [3:0] wr_freq;

    assign wr_freq   = hwdata[oit_pkg::CTL_FREQ_LSB +: 4];
    assign next_div  = wr_freq[3]       ? 4'(4'hf - wr_freq) :
                       wr_freq[2]       ? 4'(4'hc - wr_freq) :
                       4'h9;
    assign next_slow = (wr_freq[3:1] == 3'h0);

    // -------------------------------------------------------------
    // engine datapath
    // -------------------------------------------------------------
    wire        ref_event;
    wire [6:0]  step_trim;
    wire        step_in_tol;
    wire        step_at_limit;
    wire [15:0] expected;
    wire [15:0] tolerance;
    wire        engine_run;
    wire        period_done;
    wire        next_locked;
    wire        next_range;
    wire        status_change;

    assign expected  = trim_ref_select ? oit_pkg::EXPECT_USB : oit_pkg::EXPECT_XTAL;
    assign tolerance = trim_ref_select ? oit_pkg::TOL_USB    : oit_pkg::TOL_XTAL;

    // sleep freezes the engine in place
    assign engine_run  = trim_enable & ~sleep_mode;
    assign period_done = engine_run & ref_event & (state == OIT_MEASURE);

    assign next_locked = ~trim_enable                 ? 1'b0 :
                         period_done                  ? step_in_tol :
                         trim_locked;
    assign next_range  = ~trim_enable                 ? 1'b0 :
                         period_done & step_at_limit  ? 1'b1 :
                         period_done & step_in_tol    ? 1'b0 :
                         trim_out_of_range;
    assign status_change = (next_locked != trim_locked) |
                           (next_range != trim_out_of_range);

    oit_ref_edge u_ref (
        .hclk                    (hclk),
        .hresetn                 (hresetn),
        .ref_select              (trim_ref_select),
        .timer1_crystal_enable   (timer1_crystal_enable),
        .usb_frame_ref_clock     (usb_frame_ref_clock),
        .watch_crystal_ref_clock (watch_crystal_ref_clock),
        .ref_event               (ref_event)
    );

    oit_trim_step u_step (
        .measured     (tick_count),
        .expected     (expected),
        .tolerance    (tolerance),
        .trim         (osc_trim_value),
        .trim_next    (step_trim),
        .in_tolerance (step_in_tol),
        .at_limit     (step_at_limit)
    );

    // first event after enable only opens a window; no full period yet
    always_comb begin
        next_state = state;
        case (state)
            OIT_IDLE: begin
                if (engine_run) begin
                    next_state = OIT_PRIME;
                end
            end
            OIT_PRIME: begin
                if (!trim_enable) begin
                    next_state = OIT_IDLE;
                end else if (engine_run && ref_event) begin
                    next_state = OIT_MEASURE;
                end
            end
            OIT_MEASURE: begin
                if (!trim_enable) begin
                    next_state = OIT_IDLE;
                end
            end
            default: begin
                next_state = OIT_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------
    // bus slave
    // -------------------------------------------------------------
    // zero wait states; data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= wr_take;
            if (wr_take) begin
                wr_addr <= haddr[7:0];
            end
            if (rd_take) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // -------------------------------------------------------------
    // oscillator control
    // -------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_soft_enable      <= 1'b0;
            pll_mult_sel         <= 1'b0;
            pll_multiplier       <= oit_pkg::PLL_MULT_4X;
            internal_freq_select <= oit_pkg::FREQ_SEL_RESET;
            freq_div_log2        <= 4'h5;
            use_slow_rc          <= 1'b0;
            system_clock_select  <= oit_pkg::CLK_SEL_RESET;
        end else if (wr_ctl) begin
            pll_soft_enable      <= hwdata[oit_pkg::CTL_PLL_EN];
            pll_mult_sel         <= hwdata[oit_pkg::CTL_PLL_MULT];
            pll_multiplier       <= hwdata[oit_pkg::CTL_PLL_MULT] ?
                                    oit_pkg::PLL_MULT_3X : oit_pkg::PLL_MULT_4X;
            internal_freq_select <= wr_freq;
            freq_div_log2        <= next_div;
            use_slow_rc          <= next_slow;
            system_clock_select  <= hwdata[1:0];
        end
    end

    // -------------------------------------------------------------
    // trim control and engine
    // -------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_enable      <= 1'b0;
            trim_update_hold <= 1'b0;
            trim_ref_select  <= 1'b0;
        end else if (wr_tc) begin
            trim_enable      <= hwdata[oit_pkg::TC_ENABLE];
            trim_update_hold <= hwdata[oit_pkg::TC_HOLD];
            trim_ref_select  <= hwdata[oit_pkg::TC_REF_SEL];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state             <= OIT_IDLE;
            tick_count        <= 16'h0000;
            trim_locked       <= 1'b0;
            trim_out_of_range <= 1'b0;
        end else begin
            state             <= next_state;
            trim_locked       <= next_locked;
            trim_out_of_range <= next_range;
            if (!engine_run) begin
                tick_count <= tick_count;
            end else if (ref_event) begin
                tick_count <= {15'h0000, osc_tick};
            end else if (osc_tick && tick_count != 16'hffff) begin
                tick_count <= 16'(tick_count + 16'h0001);
            end
        end
    end

    // a trim write landing while trim_enable is set is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_trim_value <= oit_pkg::TRIM_RESET;
        end else if (trim_enable) begin
            if (period_done && !trim_update_hold) begin
                osc_trim_value <= step_trim;
            end
        end else if (wr_trim) begin
            osc_trim_value <= hwdata[6:0];
        end
    end

    // -------------------------------------------------------------
    // status change flag
    // -------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_irq_flag   <= 1'b0;
            trim_irq_enable <= 1'b0;
            trim_irq        <= 1'b0;
        end else begin
            if (wr_irq) begin
                trim_irq_enable <= hwdata[oit_pkg::IRQ_ENABLE];
            end
            // set beats a same-cycle software clear
            if (status_change && !sleep_mode) begin
                trim_irq_flag <= 1'b1;
            end else if (wr_irq && hwdata[oit_pkg::IRQ_FLAG]) begin
                trim_irq_flag <= 1'b0;
            end
            trim_irq <= trim_irq_flag & trim_irq_enable & ~sleep_mode;
        end
    end
endmodule
`default_nettype wire

// ===== src/oit_ref_edge.sv
// reference selection and event detection for the trim engine
// assumes both reference inputs are already synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module oit_ref_edge (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ref_select,
    input  wire logic timer1_crystal_enable,
    input  wire logic usb_frame_ref_clock,
    input  wire logic watch_crystal_ref_clock,
    output logic      ref_event
);
    logic ref_prev;
    wire  xtal_level;
    wire  ref_level;

    // crystal only runs while timer1 enables it
    assign xtal_level = watch_crystal_ref_clock & timer1_crystal_enable;
    assign ref_level  = ref_select ? usb_frame_ref_clock : xtal_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_prev  <= 1'b0;
            ref_event <= 1'b0;
        end else begin
            ref_prev  <= ref_level;
            ref_event <= ref_level & ~ref_prev;
        end
    end
endmodule
`default_nettype wire

// ===== src/oit_trim_step.sv
// one-code trim step decision from a measured reference period
// purely combinational; the caller registers every result
`timescale 1ns/1ps
`default_nettype none
module oit_trim_step (
    input  wire logic [15:0] measured,
    input  wire logic [15:0] expected,
    input  wire logic [15:0] tolerance,
    input  wire logic [6:0]  trim,
    output logic      [6:0]  trim_next,
    output logic             in_tolerance,
    output logic             at_limit
);
    wire want_up;
    wire want_down;
    wire at_max;
    wire at_min;

    // too few ticks means the oscillator is slow
    assign want_up      = ({1'b0, measured} + {1'b0, tolerance}) < {1'b0, expected};
    assign want_down    = {1'b0, measured} > ({1'b0, expected} + {1'b0, tolerance});
    assign in_tolerance = ~want_up & ~want_down;
    assign at_max       = (trim == oit_pkg::TRIM_MAX);
    assign at_min       = (trim == oit_pkg::TRIM_MIN);
    assign at_limit     = (want_up & at_max) | (want_down & at_min);
    // signed codes step by one and never wrap past the ends
    assign trim_next    = at_limit  ? trim :
                          want_up   ? 7'(trim + 7'h01) :
                          want_down ? 7'(trim - 7'h01) : trim;
endmodule
`default_nettype wire

// ===== tb/oit_monitor.sv
// assertion checker for the auto trim block, bound to its top ports
// assumes one hclk domain and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module oit_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        sleep_mode,
    input wire logic [6:0]  osc_trim_value,
    input wire logic [2:0]  pll_multiplier,
    input wire logic [3:0]  internal_freq_select,
    input wire logic        use_slow_rc,
    input wire logic        trim_irq
);
    // ----------------------------------------
    // software write tracking
    // ----------------------------------------
    logic wr_d1;
    logic wr_d2;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_d1 <= 1'b0;
            wr_d2 <= 1'b0;
        end else begin
            wr_d1 <= hsel & hready & htrans[1] & hwrite;
            wr_d2 <= wr_d1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_asleep;
        sleep_mode [*3];
    endsequence
    // a software write may move trim anywhere, so only engine moves are judged
    sequence s_engine_move;
        $changed(osc_trim_value) && !wr_d1 && !wr_d2;
    endsequence
    a_trim_step_one: assert property (
        s_engine_move |-> (osc_trim_value - $past(osc_trim_value)) inside {7'h01, 7'h7f})
        else $error("engine trim step not one code");
    a_trim_no_wrap: assert property (
        s_engine_move |-> !($past(osc_trim_value) == 7'h3f && osc_trim_value == 7'h40)
                       && !($past(osc_trim_value) == 7'h40 && osc_trim_value == 7'h3f))
        else $error("trim wrapped past a limit");
    a_irq_awake: assert property (trim_irq |-> !$past(sleep_mode))
        else $error("irq raised while asleep");
    a_trim_frozen: assert property (s_asleep |-> $stable(osc_trim_value))
        else $error("trim moved in sleep");
    a_quiet_asleep: assert property (s_asleep |-> !trim_irq)
        else $error("irq active in sleep");
    a_reset_vals: assert property ($rose(hresetn) |-> internal_freq_select == 4'h7
        && pll_multiplier == 3'h4 && osc_trim_value == 7'h00 && !trim_irq)
        else $error("bad values after reset");
    a_slow_rc_map: assert property (use_slow_rc == (internal_freq_select[3:1] == 3'h0))
        else $error("slow rc select mismatch");
    a_pll_mult_ok: assert property (pll_multiplier inside {3'h3, 3'h4})
        else $error("illegal pll multiplier");
    a_rdata_high: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule
bind oit_auto_trim oit_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .sleep_mode, .osc_trim_value, .pll_multiplier, .internal_freq_select,
    .use_slow_rc, .trim_irq);
`default_nettype wire

// ===== tb/oit_xtal_src.sv
// watch crystal reference and oscillator tick source for the trim engine
// assumes the bench sets the reference period in hclk cycles
`timescale 1ns/1ps
`default_nettype none
module oit_xtal_src (
    input  wire logic        hclk,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             ref_clk,
    output logic             osc_tick
);
    logic [15:0] cnt;
    initial begin
        cnt = 16'h0;
        ref_clk = 1'b0;
        osc_tick = 1'b0;
    end
    // stands low when stopped, one tick per cycle while running
    always @(posedge hclk) begin
        cnt <= (cnt >= period - 16'h1) ? 16'h0 : cnt + 16'h1;
        ref_clk <= run && (cnt < {1'b0, period[15:1]});
        osc_tick <= run;
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the auto trim block with a reference model
// assumes zero-wait AHB-Lite slave and crystal reference 488 ticks per period
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_mode, run;
    logic        ref_clk, osc_tick, pll_soft_enable, trim_irq, usb_on, t1en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [5:0]  stat;
    logic [15:0] prd;
    logic [6:0]  osc_trim_value;
    logic [2:0]  pll_multiplier;
    logic [3:0]  internal_freq_select, div;
    logic [7:0]  r;
    int          err_total = 0, comparisons = 0, mtrim = 0, first = 0;
    bit          mlock, moor, mflag, hold;
    oit_xtal_src u_src (.hclk, .run, .period(prd), .ref_clk, .osc_tick);
    oit_auto_trim DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_mode, .osc_tick,
        .usb_frame_ref_clock(ref_clk & usb_on), .watch_crystal_ref_clock(ref_clk),
        .timer1_crystal_enable(t1en), .secondary_osc_ready(stat[5]),
        .pll_ready_flag(stat[4]), .startup_timer_status(stat[3]), .fast_rc_ready(stat[2]),
        .slow_rc_ready(stat[1]), .fast_rc_stable(stat[0]), .osc_trim_value, .pll_soft_enable,
        .pll_multiplier, .internal_freq_select, .freq_div_log2(div), .use_slow_rc(),
        .system_clock_select(), .trim_irq);
    task automatic test_done;
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, e, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask
    // reference model of one measured period
    task automatic step(input int p);
        bit l;
        bit o;
        int want;
        int ex;
        int tl;
        l = mlock;
        o = moor;
        // expected ticks and tolerance of the selected reference
        ex = usb_on ? int'(oit_pkg::EXPECT_USB) : int'(oit_pkg::EXPECT_XTAL);
        tl = usb_on ? int'(oit_pkg::TOL_USB) : int'(oit_pkg::TOL_XTAL);
        want = (p + tl < ex) ? 1 : (p > ex + tl) ? -1 : 0;
        mlock = (want == 0);
        if (want == 0)
            moor = 0;
        else if ((want > 0 && mtrim == 63) || (want < 0 && mtrim == -64))
            moor = 1;
        else if (!hold)
            mtrim += want;
        if (l != mlock || o != moor)
            mflag = 1;
    endtask
    task automatic periods(input int n, input int p, input bit live);
        prd <= 16'(p);
        repeat (n) begin
            @(posedge ref_clk);
            repeat (6) @(posedge hclk);
            if (live && first)
                first = 0;
            else if (live)
                step(p);
            `CHK("trim", 7'(mtrim), osc_trim_value)
            `CHK("irq", mflag & !sleep_mode, trim_irq)
        end
    endtask
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        #3000000;
        err_total++;
        test_done;
    end
    initial begin
        void'($urandom(32'h3136b6ed));
        {hresetn, hsel, hwrite, sleep_mode, usb_on, htrans, haddr, hwdata} = '0;
        stat = 6'($urandom);
        {run, t1en} = 2'b11;
        prd = 16'd400;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h1c, "osc_control");
        `CHK("div", 4'h5, div)
        rchk(8'h0c, 32'h00, "trim_control");
        rchk(8'h14, 32'h00, "unmapped");
        rchk(8'h04, {24'h0, stat[5:2], 2'b00, stat[1:0]}, "status");
        bus(1'b1, 8'h00, 32'hfd);
        `CHK("mult", 3'h3, pll_multiplier)
        `CHK("pll_en", 1'b1, pll_soft_enable)
        `CHK("freq", 4'hf, internal_freq_select)
        `CHK("div hi", 4'h0, div)
        rchk(8'h00, 32'hfd, "osc_control wr");
        r = 8'($urandom);
        bus(1'b1, 8'h08, {24'h0, r});
        rchk(8'h08, {25'h0, r[6:0]}, "trim");
        `CHK("trim out", r[6:0], osc_trim_value)
        bus(1'b1, 8'h08, 32'h3c);
        mtrim = 60;
        bus(1'b1, 8'h10, 32'h2);
        bus(1'b1, 8'h0c, 32'h80);
        first = 1;
        periods(1, 400, 1);
        bus(1'b1, 8'h08, 32'h11);
        rchk(8'h08, 32'h3c, "trim kept");
        periods(4, 400, 1);
        rchk(8'h0c, 32'h82, "range set");
        bus(1'b1, 8'h10, 32'h3);
        mflag = 0;
        rchk(8'h10, 32'h2, "irq reg");
        periods(2, 488, 1);
        rchk(8'h0c, 32'h88, "locked");
        bus(1'b1, 8'h0c, 32'hc0);
        hold = 1;
        periods(1, 400, 1);
        rchk(8'h0c, 32'hc2, "held");
        bus(1'b1, 8'h0c, 32'h80);
        hold = 0;
        periods(1, 488, 1);
        periods(2, 600, 1);
        bus(1'b1, 8'h0c, 32'h00);
        rchk(8'h0c, 32'h00, "disabled");
        repeat (3) @(posedge hclk);
        bus(1'b1, 8'h08, 32'h05);
        mtrim = 5;
        rchk(8'h08, 32'h05, "manual");
        bus(1'b1, 8'h0c, 32'h10);
        usb_on <= 1'b1;
        bus(1'b1, 8'h0c, 32'h90);
        first = 1;
        periods(3, 400, 1);
        bus(1'b1, 8'h0c, 32'h10);
        usb_on <= 1'b0;
        t1en <= 1'b0;
        bus(1'b1, 8'h0c, 32'h00);
        bus(1'b1, 8'h0c, 32'h80);
        // crystal gated off: no events, trim must stay
        periods(2, 400, 0);
        t1en <= 1'b1;
        sleep_mode <= 1'b1;
        periods(3, 400, 0);
        bus(1'b1, 8'h00, 32'h04);
        rchk(8'h00, 32'h04, "osc_control slow");
        `CHK("div lo", 4'h9, div)
        test_done;
    end
endmodule
`default_nettype wire
